/* File: sstf_bank.sv */
// Purpose: Condition/transition/event/enable register bank with summaries.
// Assumes: Condition inputs synchronous to i_sys_clk; APB zero-wait.
// Notes: Reads of event registers clear the bits they return; set wins over clear.
`timescale 1ns/100ps
module sstf_bank
  import sstf_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [sstf_pkg::SSTF_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [sstf_pkg::SSTF_W-1:0] i_oper_cond,
  input wire logic [sstf_pkg::SSTF_W-1:0] i_ques_cond,
  input wire logic [sstf_pkg::SSTF_W-1:0] i_freq_cond,
  input wire logic [sstf_pkg::SSTF_W-1:0] i_limt_cond,
  input wire logic [sstf_pkg::SSTF_W-1:0] i_powr_cond,
  output logic o_oper_sum,
  output logic o_ques_sum
);
  import sstf_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [SSTF_W-1:0] cond_now [SSTF_NGRP];
  logic [SSTF_W-1:0] cond_q [SSTF_NGRP];
  logic [SSTF_W-1:0] evnt_q [SSTF_NGRP];
  logic [SSTF_W-1:0] enab_q [SSTF_NGRP];
  logic [SSTF_W-1:0] ptrn_q [SSTF_NGRP];
  logic [SSTF_W-1:0] ntrn_q [SSTF_NGRP];
  logic [SSTF_NGRP-1:0] sum;

  logic access;
  logic wr;
  logic rd;
  logic [2:0] grp;
  logic [2:0] fld;
  logic mapped;
  logic preset;

  // Completion edge only, so a stretched access cannot act twice
  assign access = i_psel && i_penable && o_pready;
  assign wr = access && i_pwrite;
  assign rd = access && !i_pwrite;
  assign grp = i_paddr[7:5];
  assign fld = i_paddr[4:2];
  assign mapped = (i_paddr[1:0] == 2'h0) && (grp <= SSTF_G_POWR)
    && (fld <= SSTF_F_NTRN);
  assign preset = wr && (i_paddr == SSTF_PRESET_ADDR);

  // ------------------------------------------------------------
  // Summaries and condition inputs
  // ------------------------------------------------------------
  // Parent event lags its subgroup event by one edge
  always_comb begin
    for (int g = 0; g < SSTF_NGRP; g++) begin
      sum[g] = |(evnt_q[g] & enab_q[g]);
    end
    cond_now[SSTF_G_OPER] = i_oper_cond;
    cond_now[SSTF_G_FREQ] = i_freq_cond;
    cond_now[SSTF_G_LIMT] = i_limt_cond;
    cond_now[SSTF_G_POWR] = i_powr_cond;
    cond_now[SSTF_G_QUES] = i_ques_cond;
    // Subgroup summaries replace their questionable inputs
    cond_now[SSTF_G_QUES][SSTF_QB_FREQ] = sum[SSTF_G_FREQ];
    cond_now[SSTF_G_QUES][SSTF_QB_LIMT] = sum[SSTF_G_LIMT];
    cond_now[SSTF_G_QUES][SSTF_QB_POWR] = sum[SSTF_G_POWR];
  end

  // ------------------------------------------------------------
  // Condition history
  // ------------------------------------------------------------
  // Zero history: a condition already high at release counts as rising
  always_ff @(posedge i_sys_clk) begin
    for (int g = 0; g < SSTF_NGRP; g++) begin
      if (!i_rst_n) begin
        cond_q[g] <= SSTF_ZERO;
      end else begin
        cond_q[g] <= cond_now[g];
      end
    end
  end

  // ------------------------------------------------------------
  // Events: detection wins over read clear
  // ------------------------------------------------------------
  logic [SSTF_W-1:0] hit [SSTF_NGRP];
  logic [SSTF_NGRP-1:0] clr;

  // Edge detect against last cycle's view of each condition
  always_comb begin
    for (int g = 0; g < SSTF_NGRP; g++) begin
      hit[g] = (ptrn_q[g] & cond_now[g] & ~cond_q[g])
        | (ntrn_q[g] & ~cond_now[g] & cond_q[g]);
      clr[g] = rd && mapped && (grp == 3'(g)) && (fld == SSTF_F_EVNT);
    end
  end

  // Clear only what the answer carried: a bit set after the setup
  // sample was never returned and must survive the read
  always_ff @(posedge i_sys_clk) begin
    for (int g = 0; g < SSTF_NGRP; g++) begin
      if (!i_rst_n) begin
        evnt_q[g] <= SSTF_ZERO;
      end else if (clr[g]) begin
        evnt_q[g] <= (evnt_q[g] & ~o_prdata[SSTF_W-1:0])
          | hit[g];
      end else begin
        evnt_q[g] <= evnt_q[g] | hit[g];
      end
    end
  end

  // ------------------------------------------------------------
  // Filters and enables
  // ------------------------------------------------------------
  // Preset rides the reset path so both give the same defaults
  always_ff @(posedge i_sys_clk) begin
    for (int g = 0; g < SSTF_NGRP; g++) begin
      if (!i_rst_n || preset) begin
        ptrn_q[g] <= SSTF_PTR_RST;
        ntrn_q[g] <= SSTF_NTR_RST;
        enab_q[g] <= SSTF_ENA_RST;
      end else if (wr && mapped && (grp == 3'(g))) begin
        if (fld == SSTF_F_PTRN) begin
          ptrn_q[g] <= i_pwdata[SSTF_W-1:0];
        end
        if (fld == SSTF_F_NTRN) begin
          ntrn_q[g] <= i_pwdata[SSTF_W-1:0];
        end
        if (fld == SSTF_F_ENAB) begin
          enab_q[g] <= i_pwdata[SSTF_W-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // APB answer, registered
  // ------------------------------------------------------------
  logic [SSTF_W-1:0] rd_val;
  always_comb begin
    rd_val = SSTF_ZERO;
    if (mapped) begin
      unique case (fld)
        SSTF_F_COND: rd_val = cond_now[grp];
        SSTF_F_EVNT: rd_val = evnt_q[grp];
        SSTF_F_ENAB: rd_val = enab_q[grp];
        SSTF_F_PTRN: rd_val = ptrn_q[grp];
        SSTF_F_NTRN: rd_val = ntrn_q[grp];
        default: rd_val = SSTF_ZERO;
      endcase
    end
  end

  // Ready is registered from setup, so it comes in the first access cycle with the data

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      // Preset address is write-only; a read of it errors
      o_pslverr <= i_psel && !i_penable && !mapped
        && !(i_pwrite && i_paddr == SSTF_PRESET_ADDR);
      o_prdata <= (i_psel && !i_penable && !i_pwrite)
        ? {16'h0, rd_val} : 32'h0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_oper_sum <= 1'b0;
      o_ques_sum <= 1'b0;
    end else begin
      o_oper_sum <= sum[SSTF_G_OPER];
      o_ques_sum <= sum[SSTF_G_QUES];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  ptr_sets_event_a: assert property (
    (ptrn_q[0][0] && i_oper_cond[0] && !cond_q[0][0])
      |=> evnt_q[0][0])
    else $error("rising edge missed operation event");
  ntr_sets_event_a: assert property (
    (ntrn_q[0][1] && !i_oper_cond[1] && cond_q[0][1])
      |=> evnt_q[0][1])
    else $error("falling edge missed operation event");
  event_sticky_a: assert property (
    (evnt_q[1] != SSTF_ZERO && !(rd && fld == SSTF_F_EVNT))
      |=> (evnt_q[1] & $past(evnt_q[1])) == $past(evnt_q[1]))
    else $error("event bit lost without read");
  ques_rd_clear_a: assert property (
    (rd && mapped && grp == SSTF_G_QUES && fld == SSTF_F_EVNT
      && ptrn_q[1] == SSTF_ZERO && ntrn_q[1] == SSTF_ZERO)
      |=> evnt_q[1] == SSTF_ZERO)
    else $error("questionable event not cleared by read");
  cond_rd_keep_a: assert property (
    (rd && fld == SSTF_F_COND) |=> (evnt_q[2] & $past(evnt_q[2]))
      == $past(evnt_q[2]))
    else $error("condition read disturbed events");
  oper_rd_clear_a: assert property (
    (rd && mapped && grp == SSTF_G_OPER && fld == SSTF_F_EVNT
      && ptrn_q[0] == SSTF_ZERO && ntrn_q[0] == SSTF_ZERO)
      |=> evnt_q[0] == SSTF_ZERO)
    else $error("operation event not cleared by read");
  preset_vals_a: assert property (
    preset |=> ptrn_q[3] == SSTF_PTR_RST && ntrn_q[3] == SSTF_NTR_RST
      && enab_q[0] == SSTF_ENA_RST && enab_q[1] == SSTF_ENA_RST)
    else $error("preset values wrong");
  sum_follow_a: assert property (
    (|(evnt_q[0] & enab_q[0])) |=> o_oper_sum)
    else $error("operation summary not raised");
  sub_to_parent_a: assert property (
    ($rose(sum[SSTF_G_FREQ]) && ptrn_q[1][SSTF_QB_FREQ])
      |=> evnt_q[1][SSTF_QB_FREQ])
    else $error("subgroup summary not in parent event");
  enab_write_a: assert property (
    (wr && mapped && grp == SSTF_G_LIMT && fld == SSTF_F_ENAB && !preset)
      |=> enab_q[3] == $past(i_pwdata[15:0]))
    else $error("enable mask write lost");
  ques_ptr_event_a: assert property (
    (ptrn_q[1][SSTF_QB_LIMT] && cond_now[1][SSTF_QB_LIMT]
      && !cond_q[1][SSTF_QB_LIMT]) |=> evnt_q[1][SSTF_QB_LIMT])
    else $error("rising edge missed questionable event");
  powr_ntr_event_a: assert property (
    (ntrn_q[4][1] && !i_powr_cond[1] && cond_q[4][1]) |=> evnt_q[4][1])
    else $error("falling edge missed power event");
  ques_enab_write_a: assert property (
    (wr && mapped && grp == SSTF_G_QUES && fld == SSTF_F_ENAB && !preset)
      |=> enab_q[1] == $past(i_pwdata[15:0]))
    else $error("questionable enable write lost");
  oper_ntr_write_a: assert property (
    (wr && mapped && grp == SSTF_G_OPER && fld == SSTF_F_NTRN && !preset)
      |=> ntrn_q[0] == $past(i_pwdata[15:0]))
    else $error("operation falling filter write lost");
  oper_ptr_write_a: assert property (
    (wr && mapped && grp == SSTF_G_OPER && fld == SSTF_F_PTRN && !preset)
      |=> ptrn_q[0] == $past(i_pwdata[15:0]))
    else $error("operation rising filter write lost");
  limt_ntr_write_a: assert property (
    (wr && mapped && grp == SSTF_G_LIMT && fld == SSTF_F_NTRN && !preset)
      |=> ntrn_q[3] == $past(i_pwdata[15:0]))
    else $error("limit falling filter write lost");
  preset_ques_a: assert property (
    preset |=> ptrn_q[1] == SSTF_PTR_RST && ntrn_q[2] == SSTF_NTR_RST
      && enab_q[4] == SSTF_ENA_RST)
    else $error("preset values wrong in subgroups");
  ques_sum_rise_a: assert property (
    (|(evnt_q[1] & enab_q[1])) |=> o_ques_sum)
    else $error("questionable summary not raised");
  event_kept_a: assert property (
    clr[SSTF_G_OPER] |=> (evnt_q[0] & $past(evnt_q[0] & ~o_prdata[15:0]))
      == $past(evnt_q[0] & ~o_prdata[15:0]))
    else $error("unreturned operation event lost on read");
  event_rd_data_a: assert property (
    (i_psel && !i_penable && !i_pwrite && mapped && fld == SSTF_F_EVNT)
      |=> o_prdata[15:0] == $past(evnt_q[grp]))
    else $error("event read data wrong");
  cond_rd_data_a: assert property (
    (i_psel && !i_penable && !i_pwrite && mapped && fld == SSTF_F_COND)
      |=> o_prdata[15:0] == $past(cond_now[grp]))
    else $error("condition read data wrong");

  // ------------------------------------------------------------
  // Protocol checks
  // ------------------------------------------------------------
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held past one cycle");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");

  // Main scenarios
  oper_event_c: cover property (evnt_q[0] != SSTF_ZERO);
  ques_sum_c: cover property (o_ques_sum);
  preset_c: cover property (preset);
  read_clear_c: cover property (rd && fld == SSTF_F_EVNT
    && evnt_q[1] != SSTF_ZERO);
  race_keep_c: cover property (clr[SSTF_G_OPER]
    && hit[SSTF_G_OPER] != SSTF_ZERO);
endmodule : sstf_bank

/* File: sstf_pkg.sv */
// Purpose: Constants for the status transition filter register bank.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Group index 0 operation, 1 questionable, 2 freq, 3 limit, 4 power.
package sstf_pkg;
  localparam int SSTF_W = 16;
  localparam int SSTF_NGRP = 5;
  localparam int SSTF_AW = 8;
  localparam logic [2:0] SSTF_G_OPER = 3'h0;
  localparam logic [2:0] SSTF_G_QUES = 3'h1;
  localparam logic [2:0] SSTF_G_FREQ = 3'h2;
  localparam logic [2:0] SSTF_G_LIMT = 3'h3;
  localparam logic [2:0] SSTF_G_POWR = 3'h4;
  // Address = {group[2:0], field[2:0], 2'b00}
  localparam logic [2:0] SSTF_F_COND = 3'h0;
  localparam logic [2:0] SSTF_F_EVNT = 3'h1;
  localparam logic [2:0] SSTF_F_ENAB = 3'h2;
  localparam logic [2:0] SSTF_F_PTRN = 3'h3;
  localparam logic [2:0] SSTF_F_NTRN = 3'h4;
  localparam logic [7:0] SSTF_PRESET_ADDR = 8'hFC;
  localparam logic [15:0] SSTF_PTR_RST = 16'hFFFF;
  localparam logic [15:0] SSTF_NTR_RST = 16'h0000;
  localparam logic [15:0] SSTF_ENA_RST = 16'h0000;
  localparam logic [15:0] SSTF_ZERO = 16'h0000;
  // Questionable condition bit positions fed by subgroup summaries
  localparam int SSTF_QB_FREQ = 5;
  localparam int SSTF_QB_LIMT = 9;
  localparam int SSTF_QB_POWR = 3;
endpackage : sstf_pkg

/* File: sstf_tb.sv */
// Purpose: Self-checking bench for the status register bank.
// Assumes: APB answers in one access cycle; summaries are registered.
// Notes: Conditions change on rising edges, bus sampled at rising ones.
`timescale 1ns/100ps
module testbench;
  import sstf_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [15:0] e;} sstf_row_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, osum, qsum;
  logic [15:0] cnd [5] = '{default: 16'h0000};
  logic [15:0] e;
  logic [2:0] g;
  int n_mismatch = 0;
  int tests_run = 0;
  int qb [3] = '{SSTF_QB_FREQ, SSTF_QB_LIMT, SSTF_QB_POWR};
  sstf_row_t rows [8] = '{'{8'h10, 32'hFFFF_FFFF, 16'hFFFF},
    '{8'h0C, 32'h0, 16'h0000}, '{8'h28, 32'hABCD_1234, 16'h1234},
    '{8'h30, 32'h8001, 16'h8001}, '{8'h2C, 32'h00FF, 16'h00FF},
    '{8'h48, 32'hFFFF, 16'hFFFF}, '{8'h70, 32'h5A5A, 16'h5A5A},
    '{8'h00, 32'h1234, 16'h0000}};
  sstf_bank sstf_bank_inst (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_oper_cond(cnd[0]), .i_ques_cond(cnd[1]),
    .i_freq_cond(cnd[2]), .i_limt_cond(cnd[3]), .i_powr_cond(cnd[4]),
    .o_oper_sum(osum), .o_ques_sum(qsum));
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] ad(input logic [2:0] gr, fl);
    return {gr, fl, 2'h0};
  endfunction : ad
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // ----------------------------------------
  // Bus master: holds the request until pready
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    if (pready !== 1'h1) begin
      n_mismatch++;
      final_report();
    end
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [15:0] x, string nm);
    bus(1'h0, a, 32'h0);
    chk(nm, rd, {16'h0000, x});
  endtask : rdchk
  task automatic setc(input int i, input logic [15:0] v, input int n);
    @(posedge clk);
    cnd[i] <= v;
    repeat (n) @(posedge clk);
  endtask : setc
  task automatic defaults();
    for (logic [2:0] i = 0; i < 5; i++) begin
      rdchk(ad(i, SSTF_F_PTRN), 16'hFFFF, "ptr default");
      rdchk(ad(i, SSTF_F_NTRN), 16'h0000, "ntr default");
      rdchk(ad(i, SSTF_F_ENAB), 16'h0000, "ena default");
      rdchk(ad(i, SSTF_F_EVNT), 16'h0000, "ev default");
    end
  endtask : defaults
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    defaults();
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'h1, rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e, "row");
    end
    bus(1'h1, SSTF_PRESET_ADDR, 32'h0);
    chk("preset err", err, 1'h0);
    defaults();
    $display("test rows and preset done");
    bus(1'h1, 8'h0C, 32'h0002);
    bus(1'h1, 8'h10, 32'h0001);
    setc(0, 16'h0003, 3);
    rdchk(8'h00, 16'h0003, "oper cond");
    rdchk(8'h04, 16'h0002, "oper ev rise");
    rdchk(8'h04, 16'h0000, "oper ev clear");
    setc(0, 16'h0000, 3);
    rdchk(8'h04, 16'h0001, "oper ev fall");
    bus(1'h1, SSTF_PRESET_ADDR, 32'h0);
    bus(1'h1, 8'h08, 32'h0020);
    setc(0, 16'h0010, 4);
    chk("oper sum masked", osum, 1'h0);
    bus(1'h1, 8'h08, 32'h0030);
    repeat (2) @(posedge clk);
    chk("oper sum", osum, 1'h1);
    rdchk(8'h04, 16'h0010, "oper ev");
    repeat (2) @(posedge clk);
    chk("oper sum clear", osum, 1'h0);
    setc(0, 16'h0000, 1);
    fork
      rdchk(8'h04, 16'h0000, "ev race read");
      begin
        @(posedge clk);
        cnd[0] <= 16'h0100;
        @(posedge clk);
        cnd[0] <= 16'h0300;
      end
    join
    rdchk(8'h04, 16'h0300, "ev race kept");
    setc(0, 16'h0000, 1);
    $display("test operation group done");
    for (int i = 0; i < 3; i++) begin
      g = 3'(i + 2);
      e = 16'h0001 << qb[i];
      bus(1'h1, 8'h28, {16'h0000, e});
      bus(1'h1, ad(g, SSTF_F_ENAB), 32'h0001);
      setc(i + 2, 16'h0001, 4);
      chk("ques sum", qsum, 1'h1);
      rdchk(8'h20, e, "ques cond");
      rdchk(ad(g, SSTF_F_COND), 16'h0001, "sub cond");
      rdchk(ad(g, SSTF_F_EVNT), 16'h0001, "sub ev");
      rdchk(ad(g, SSTF_F_EVNT), 16'h0000, "sub ev clear");
      rdchk(8'h24, e, "ques ev");
      rdchk(8'h24, 16'h0000, "ques ev clear");
      setc(i + 2, 16'h0000, 3);
      chk("ques sum clear", qsum, 1'h0);
    end
    bus(1'h1, 8'h90, 32'h0002);
    setc(4, 16'h0002, 2);
    rdchk(8'h84, 16'h0002, "powr ev rise");
    setc(4, 16'h0000, 2);
    rdchk(8'h84, 16'h0002, "powr ev fall");
    $display("test subgroups done");
    bus(1'h1, 8'h0C, 32'h0000);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    defaults();
    chk("reset sums", {30'h0, osum, qsum}, 32'h0);
    $display("test mid reset done");
    bus(1'h0, 8'hE0, 32'h0);
    chk("bad read err", err, 1'h1);
    chk("bad read data", rd, 32'h0);
    $display("test unmapped done");
    final_report();
  end
endmodule : testbench
